/* spm_cfg.svh */
// register map, field positions and reset values of the serial port
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SPM_OFS_CLK_CTRL 8'h00
`define SPM_OFS_PORT_CTRL 8'h01
`define SPM_OFS_STATUS 8'h02
`define SPM_OFS_DATA_LOW 8'h03
`define SPM_OFS_DATA_HIGH 8'h04
`define SPM_OFS_INT_MASK 8'h05

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SPM_BC_MSB 3
`define SPM_BC_LSB 0
`define SPM_RATE_MSB 6
`define SPM_RATE_LSB 4
`define SPM_BIT_ENABLE 7
`define SPM_BIT_MASTER 6
`define SPM_ST_DONE 0
`define SPM_ST_TX_EMPTY 1
`define SPM_ST_READY_PIN 2
`define SPM_ST_FAULT 3
`define SPM_ST_BUSY 4

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define SPM_RST_CLK_CTRL 8'h07
`define SPM_RST_PORT_CTRL 8'h00
`define SPM_RST_INT_MASK 8'h00
`define SPM_MIN_BITS 5'h07
`define SPM_MIN_CODE 4'h6
`define SPM_DIV_BASE 9'h002

`endif

/* spm_pkg.sv */
// types shared by the serial port modules
package spm_pkg;

    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_LEAD,
        SPM_TRAIL
    } spm_state_t;

    // one bit per shared port pin
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
        logic rdy;
    } spm_pins_t;

endpackage : spm_pkg

/* spm_sync.sv */
// two-flop synchroniser for the shared port pins
`timescale 1ns/10ps

module spm_sync #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import spm_pkg::*;

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : spm_sync

/* spm_clkdiv.sv */
// serial clock divider: one tick per half period of the serial clock
`timescale 1ns/10ps
`include "spm_cfg.svh"

module spm_clkdiv (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic [2:0] rate,
    output logic tick
);
    import spm_pkg::*;

    logic [7:0] cnt_q;
    // half period is 2 << rate source cycles
    wire [8:0] half = `SPM_DIV_BASE << rate;
    wire [7:0] limit = 8'(half - 9'h001);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else if (clear) begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_q == limit) begin
            cnt_q <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick <= 1'b0;
        end
    end

endmodule : spm_clkdiv

/* spm_port.sv */
// serial peripheral port: registers, shift engine, pins and interrupt
// Functional notes
// - one 16-bit shift register plus separate 16-bit transmit and receive buffers.
// - word length of 7 to 16 bits comes from bit count field bits 3..0 of clock control.
// - an exchange ends when the shifted bit count reaches the programmed count.
// - serial clock rate is chosen by bits 6..4 of clock control.
// - bit 7 of port control enables the port and its clock divider.
// - setting the enable returns the shift engine, bit counter and pending-buffer flag to their initial values.
// - with the port enabled as master, writing the low data byte starts a new exchange.
// - a busy flag is set during an exchange and shows in status bit 4.
// - an active-low select picks one slave; an unselected slave stays off the bus except for data ready, which it keeps driving.
// - in master mode an asserted select input is a mode fault in status bit 3.
// - data moves both ways at once on two lines, in step with the serial clock.
// - the serial clock comes from an own divider fed by the oscillator clock.
// - the port works as master or as slave.
// - five shared pins: clock, two data lines, slave select and data ready.
`timescale 1ns/10ps
`include "spm_cfg.svh"

module spm_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rd_data,
    output logic irq,
    input wire spm_pkg::spm_pins_t pin_i,
    output spm_pkg::spm_pins_t pin_o,
    output spm_pkg::spm_pins_t pin_oe_n
);
    import spm_pkg::*;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic [4:0] word_len(input logic [3:0] bc);
        // codes below six are clamped to the shortest word
        word_len = (bc < `SPM_MIN_CODE) ? `SPM_MIN_BITS : {1'b0, bc} + 5'h01;
    endfunction : word_len

    function automatic logic [15:0] len_mask(input logic [4:0] n);
        logic [16:0] ones;
        ones = (17'h00001 << n) - 17'h00001;
        len_mask = ones[15:0];
    endfunction : len_mask

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] clk_ctrl_q;
    logic [7:0] port_ctrl_q;
    logic [7:0] mask_q;
    logic done_q;
    logic fault_q;
    logic [15:0] tx_buf_q;
    logic [15:0] rx_buf_q;
    logic [15:0] shreg_q;
    logic tx_full_q;
    spm_state_t state_q;
    spm_state_t state_d;
    logic [4:0] cnt_q;
    logic in_bit_q;
    logic sck_prev_q;
    spm_pins_t pin_s;
    logic tick;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire sel_clk = addr == `SPM_OFS_CLK_CTRL;
    wire sel_port = addr == `SPM_OFS_PORT_CTRL;
    wire sel_status = addr == `SPM_OFS_STATUS;
    wire sel_low = addr == `SPM_OFS_DATA_LOW;
    wire sel_high = addr == `SPM_OFS_DATA_HIGH;
    wire sel_mask = addr == `SPM_OFS_INT_MASK;

    wire port_en = port_ctrl_q[`SPM_BIT_ENABLE];
    wire is_master = port_ctrl_q[`SPM_BIT_MASTER];
    wire [4:0] len = word_len(clk_ctrl_q[`SPM_BC_MSB:`SPM_BC_LSB]);
    wire [2:0] rate = clk_ctrl_q[`SPM_RATE_MSB:`SPM_RATE_LSB];

    // enabling clears the engine in the write cycle; it stays clear while off
    wire en_rise = wr && sel_port && wr_data[`SPM_BIT_ENABLE] && !port_en;
    wire init = en_rise || !port_en;

    wire busy = state_q != SPM_IDLE;
    wire idle = state_q == SPM_IDLE;
    wire slave_sel = port_en && !is_master && !pin_s.ss_n;
    wire fault_ev = port_en && is_master && !pin_s.ss_n;
    wire sck_rise = pin_s.sck && !sck_prev_q;
    wire sck_fall = !pin_s.sck && sck_prev_q;

    wire m_start = port_en && is_master && idle && tx_full_q && pin_s.ss_n;
    wire s_start = slave_sel && idle;
    wire start = m_start || s_start;

    // master paces itself from the divider, slave follows the clock pin
    wire ev_rise = (state_q == SPM_LEAD) && (is_master ? tick : sck_rise);
    wire ev_fall = (state_q == SPM_TRAIL) && (is_master ? tick : sck_fall);
    wire in_pin = is_master ? pin_s.miso : pin_s.mosi;
    wire last = cnt_q == (len - 5'h01);
    wire done_ev = ev_fall && last && !init;
    wire slave_abort = !is_master && busy && pin_s.ss_n;
    wire abort = fault_ev || slave_abort;
    wire out_bit = shreg_q[4'(len - 5'h01)];
    wire [15:0] rx_word = len_mask(len) & {shreg_q[14:0], in_bit_q};

    wire clr_done = wr && sel_status && wr_data[`SPM_ST_DONE];
    wire clr_fault = wr && sel_status && wr_data[`SPM_ST_FAULT];
    wire [7:0] status = {3'h0, busy, fault_q, pin_s.rdy, !tx_full_q, done_q};
    wire [7:0] rd_mux = sel_clk ? clk_ctrl_q :
                        sel_port ? port_ctrl_q :
                        sel_status ? status :
                        sel_low ? rx_buf_q[7:0] :
                        sel_high ? rx_buf_q[15:8] :
                        sel_mask ? mask_q : 8'h00;

    // ------------------------------------------------------------------
    // pin synchroniser and clock divider
    // ------------------------------------------------------------------
    spm_sync #(
        .W(5)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d(pin_i),
        .q(pin_s)
    );

    // divider restarts between words so every first half period is full
    spm_clkdiv u_div (
        .clk(clk),
        .reset(reset),
        .clear(init || idle),
        .rate(rate),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_ctrl_q <= `SPM_RST_CLK_CTRL;
            port_ctrl_q <= `SPM_RST_PORT_CTRL;
            mask_q <= `SPM_RST_INT_MASK;
            tx_buf_q <= 16'h0000;
        end else if (wr) begin
            if (sel_clk) begin
                clk_ctrl_q <= wr_data;
            end else if (sel_port) begin
                port_ctrl_q <= wr_data;
            end else if (sel_mask) begin
                mask_q <= wr_data;
            end else if (sel_low) begin
                tx_buf_q[7:0] <= wr_data;
            end else if (sel_high) begin
                tx_buf_q[15:8] <= wr_data;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            done_q <= done_ev || (done_q && !clr_done);
            fault_q <= fault_ev || (fault_q && !clr_fault);
        end
    end

    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SPM_IDLE: begin
                if (start) begin
                    state_d = SPM_LEAD;
                end
            end
            SPM_LEAD: begin
                if (ev_rise) begin
                    state_d = SPM_TRAIL;
                end
            end
            SPM_TRAIL: begin
                if (ev_fall) begin
                    state_d = last ? SPM_IDLE : SPM_LEAD;
                end
            end
            default: begin
                state_d = SPM_IDLE;
            end
        endcase
        if (init || abort) begin
            state_d = SPM_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= SPM_IDLE;
            sck_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sck_prev_q <= pin_s.sck;
        end
    end

    // a pending buffer lets the next word follow the current one at once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_full_q <= 1'b0;
        end else if (init) begin
            tx_full_q <= 1'b0;
        end else if (wr && sel_low) begin
            tx_full_q <= 1'b1;
        end else if (start) begin
            tx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shreg_q <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (init) begin
            shreg_q <= 16'h0000;
            cnt_q <= 5'h00;
        end else if (start) begin
            shreg_q <= tx_buf_q;
            cnt_q <= 5'h00;
        end else if (ev_fall) begin
            shreg_q <= {shreg_q[14:0], in_bit_q};
            cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_bit_q <= 1'b0;
            rx_buf_q <= 16'h0000;
        end else begin
            if (ev_rise) begin
                in_bit_q <= in_pin;
            end
            if (done_ev) begin
                rx_buf_q <= rx_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // pins, read data and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_o <= '0;
            pin_oe_n <= '1;
        end else begin
            pin_o.sck <= is_master && (state_q == SPM_TRAIL);
            pin_o.mosi <= out_bit;
            pin_o.miso <= out_bit;
            pin_o.ss_n <= 1'b1;
            pin_o.rdy <= tx_full_q;
            pin_oe_n.sck <= !(port_en && is_master);
            pin_oe_n.mosi <= !(port_en && is_master);
            pin_oe_n.miso <= !slave_sel;
            pin_oe_n.ss_n <= 1'b1;
            pin_oe_n.rdy <= !(port_en && !is_master);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data <= 8'h00;
            irq <= 1'b0;
        end else begin
            rd_data <= rd ? rd_mux : 8'h00;
            irq <= (done_q && mask_q[`SPM_ST_DONE]) || (fault_q && mask_q[`SPM_ST_FAULT]);
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_start_load;
        @(posedge clk) disable iff (reset)
        (start && !init && !abort) |=> (shreg_q == $past(tx_buf_q)) && busy;
    endproperty
    a_start_load: assert property (p_start_load) else $error("start did not load buffer");

    property p_done_rx;
        @(posedge clk) disable iff (reset)
        done_ev |=> rx_buf_q == $past(rx_word);
    endproperty
    a_done_rx: assert property (p_done_rx) else $error("received word not stored");

    property p_count_end;
        @(posedge clk) disable iff (reset)
        (ev_fall && last) |=> idle && done_q;
    endproperty
    a_count_end: assert property (p_count_end) else $error("exchange did not end");

    property p_fault_set;
        @(posedge clk) disable iff (reset)
        fault_ev |=> fault_q && idle;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("mode fault not taken");

    sequence s_idle_two;
        idle [*2];
    endsequence

    property p_sck_idle;
        @(posedge clk) disable iff (reset)
        s_idle_two |-> !pin_o.sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock pulse while idle");

    // an unselected slave lets go of its data line and drops any word in flight
    property p_unsel_release;
        @(posedge clk) disable iff (reset)
        (port_en && !is_master && pin_s.ss_n) |=> pin_oe_n.miso && idle;
    endproperty
    a_unsel_release: assert property (p_unsel_release) else $error("unselected slave drives");

    property p_enable_clears;
        @(posedge clk) disable iff (reset)
        en_rise |=> idle && !tx_full_q && (cnt_q == 5'h00) && port_en;
    endproperty
    a_enable_clears: assert property (p_enable_clears) else $error("enable did not clear");

    property p_write_starts;
        @(posedge clk) disable iff (reset)
        (wr && sel_low && port_en && is_master && idle && !en_rise) |=> tx_full_q ##1 busy || fault_q;
    endproperty
    a_write_starts: assert property (p_write_starts) else $error("write did not start");

    property p_len_range;
        @(posedge clk) disable iff (reset)
        (len >= `SPM_MIN_BITS) && (len <= 5'h10);
    endproperty
    a_len_range: assert property (p_len_range) else $error("word length out of range");

    property p_busy_read;
        @(posedge clk) disable iff (reset)
        (rd && sel_status) |=> rd_data[`SPM_ST_BUSY] == $past(busy);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy flag misreported");

endmodule : spm_port

/* spm_peer.sv */
// far-side serial device: answers as a slave or drives whole frames as a master
`timescale 1ns/10ps

module spm_peer (
    input wire logic clk,
    input wire logic [4:0] len,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    output logic drv_sck,
    output logic drv_mosi,
    output logic drv_miso,
    output logic [15:0] rx_q
);
    logic [15:0] sh_q = 16'h0000;
    logic [15:0] rx_r = 16'h0000;
    logic sck_q = 1'b0;
    logic sck_drv_q = 1'b0;
    logic frm_q = 1'b0;
    logic tog_q = 1'b0;

    assign rx_q = rx_r;
    // clock stands still at 0 outside frames
    assign drv_sck = sck_drv_q;
    // released lines toggle so a stale value is never mistaken for data
    assign drv_miso = (!sel_n && !frm_q) ? sh_q[len - 5'd1] : tog_q;
    assign drv_mosi = frm_q ? sh_q[len - 5'd1] : tog_q;

    // ----------------------------------------------------------------
    // slave role: sample at the rising clock, shift at the falling one
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        tog_q <= ~tog_q;
        sck_q <= sck;
        if (!sel_n && !frm_q && sck && !sck_q) begin
            rx_r <= {rx_r[14:0], mosi};
        end
        if (!sel_n && !frm_q && !sck && sck_q) begin
            sh_q <= sh_q << 1;
        end
    end

    task automatic load(input logic [15:0] w);
        @(posedge clk);
        sh_q <= w;
        rx_r <= 16'h0000;
    endtask : load

    // ----------------------------------------------------------------
    // master role: eight cycles per half period, bit valid before rise
    // ----------------------------------------------------------------
    task automatic run_master(input int n);
        @(posedge clk);
        frm_q <= 1'b1;
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge clk);
            sck_drv_q <= 1'b1;
            rx_r <= {rx_r[14:0], miso};
            repeat (8) @(posedge clk);
            sck_drv_q <= 1'b0;
            sh_q <= sh_q << 1;
        end
        repeat (8) @(posedge clk);
        frm_q <= 1'b0;
    endtask : run_master
endmodule : spm_peer

/* spm_port_tb.sv */
// self-checking bench of the serial port against a far-side peer
`timescale 1ns/10ps

module spm_port_tb;
    import spm_pkg::*;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rd_data;
    logic irq;
    spm_pins_t pin_w;
    spm_pins_t pin_o;
    spm_pins_t pin_oe_n;
    logic ss_n_tb = 1'b1;
    logic psel_n = 1'b1;
    logic [4:0] plen = 5'd8;
    logic p_sck;
    logic p_mosi;
    logic p_miso;
    logic [15:0] p_rx;
    logic sck_d = 1'b0;
    int rises = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int errors = 0;
    int check_count = 0;

    always #2 clk = ~clk;

    // ----------------------------------------------------------------
    // wire levels from every party's enable; select is never driven
    // ----------------------------------------------------------------
    always_comb begin
        pin_w.sck = !pin_oe_n.sck ? pin_o.sck : p_sck;
        pin_w.mosi = !pin_oe_n.mosi ? pin_o.mosi : p_mosi;
        pin_w.miso = !pin_oe_n.miso ? pin_o.miso : p_miso;
        pin_w.ss_n = ss_n_tb;
        pin_w.rdy = !pin_oe_n.rdy ? pin_o.rdy : 1'b0;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        sck_d <= pin_w.sck;
        if (pin_w.sck && !sck_d) begin
            rises <= rises + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end

    spm_port dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr(wr),
        .rd(rd), .rd_data(rd_data), .irq(irq), .pin_i(pin_w), .pin_o(pin_o),
        .pin_oe_n(pin_oe_n));

    spm_peer peer (.clk(clk), .len(plen), .sel_n(psel_n), .sck(pin_w.sck),
        .mosi(pin_w.mosi), .miso(pin_w.miso), .drv_sck(p_sck), .drv_mosi(p_mosi),
        .drv_miso(p_miso), .rx_q(p_rx));

    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic results();
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_rd

    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 2000; i++) begin
            reg_rd(8'h02, s);
            if (s[4] === 1'b0) begin
                return;
            end
        end
        errors++;
        $display("Error %0t: port stayed busy", $time);
        results();
    endtask : wait_idle

    // one master word: count, rate, data both ways, status and interrupt
    task automatic m_xfer(input logic [3:0] bc, input logic [2:0] rt,
        input logic [15:0] tw, input logic [15:0] pw);
        logic [4:0] n;
        logic [15:0] m;
        logic [7:0] lo;
        logic [7:0] hi;
        int r0;
        n = (bc < 4'h6) ? 5'd7 : {1'b0, bc} + 5'd1;
        m = 16'hffff >> (5'd16 - n);
        plen <= n;
        psel_n <= 1'b0;
        reg_wr(8'h00, {1'b0, rt, bc});
        peer.load(pw);
        r0 = rises;
        reg_wr(8'h04, tw[15:8]);
        reg_wr(8'h03, tw[7:0]);
        repeat (2) @(posedge clk);
        reg_rd(8'h02, lo);
        chk({8'h00, lo & 8'h12}, 16'h0012);
        wait_idle();
        chk(16'(rises - r0), {11'h000, n});
        chk(16'(gap), 16'(4 << rt));
        chk(p_rx & m, tw & m);
        reg_rd(8'h03, lo);
        reg_rd(8'h04, hi);
        chk({hi, lo} & m, pw & m);
        reg_rd(8'h02, lo);
        chk({8'h00, lo}, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        reg_wr(8'h02, 8'h01);
        reg_rd(8'h02, lo);
        chk({8'h00, lo}, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
    endtask : m_xfer

    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("Error %0t: run did not finish", $time);
        results();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] s;
        logic [3:0] bcs [4] = '{4'h0, 4'h6, 4'h7, 4'hf};
        logic [2:0] rts [4] = '{3'h2, 3'h3, 3'h2, 3'h3};
        int r0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        reg_rd(8'h00, s);
        chk({8'h00, s}, 16'h0007);
        reg_rd(8'h01, s);
        chk({8'h00, s}, 16'h0000);
        reg_rd(8'h02, s);
        chk({8'h00, s}, 16'h0002);
        reg_wr(8'h3f, 8'h5a);
        reg_rd(8'h3f, s);
        chk({8'h00, s}, 16'h0000);
        reg_wr(8'h05, 8'h01);
        reg_rd(8'h05, s);
        chk({8'h00, s}, 16'h0001);
        reg_wr(8'h01, 8'hc0);
        reg_rd(8'h01, s);
        chk({8'h00, s}, 16'h00c0);
        for (int i = 0; i < 4; i++) begin
            m_xfer(bcs[i], rts[i], 16'h9b5a, 16'h36c9);
        end
        // peer stays selected across words so no select edge lands between calls
        psel_n <= 1'b1;
        // another master on the select line
        reg_wr(8'h05, 8'h08);
        ss_n_tb <= 1'b0;
        repeat (6) @(posedge clk);
        ss_n_tb <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(8'h02, s);
        chk({8'h00, s & 8'h18}, 16'h0008);
        chk({15'h0000, irq}, 16'h0001);
        reg_wr(8'h02, 8'h08);
        reg_rd(8'h02, s);
        chk({8'h00, s & 8'h08}, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        // slave role, peer drives the frame
        reg_wr(8'h01, 8'h80);
        reg_wr(8'h00, 8'h27);
        plen <= 5'd8;
        reg_wr(8'h04, 8'h00);
        reg_wr(8'h03, 8'ha6);
        repeat (3) @(posedge clk);
        chk({11'h000, pin_oe_n.ss_n, pin_oe_n.mosi, pin_oe_n.sck, pin_oe_n.rdy, pin_o.rdy},
            16'h001d);
        peer.load(16'h005c);
        ss_n_tb <= 1'b0;
        peer.run_master(8);
        ss_n_tb <= 1'b1;
        repeat (4) @(posedge clk);
        chk({15'h0000, pin_oe_n.miso}, 16'h0001);
        wait_idle();
        chk(p_rx & 16'h00ff, 16'h00a6);
        reg_rd(8'h03, s);
        chk({8'h00, s}, 16'h005c);
        // disable in mid-word, then a data write while disabled
        reg_wr(8'h01, 8'hc0);
        reg_wr(8'h00, 8'h3f);
        psel_n <= 1'b0;
        reg_wr(8'h03, 8'h77);
        repeat (100) @(posedge clk);
        reg_wr(8'h01, 8'h40);
        repeat (4) @(posedge clk);
        r0 = rises;
        repeat (100) @(posedge clk);
        chk(16'(rises - r0), 16'h0000);
        reg_rd(8'h02, s);
        chk({8'h00, s & 8'h10}, 16'h0000);
        reg_wr(8'h03, 8'h11);
        repeat (10) @(posedge clk);
        reg_rd(8'h02, s);
        chk({8'h00, s & 8'h10}, 16'h0000);
        results();
    end
endmodule : spm_port_tb
